// File: logic/hspp_regs.vh
// Purpose: Register map, field positions and timing counts for the hub strap
//          and port power block.
// Assumes: 32-bit register words on a plain strobe port, byte addresses.
// Notes:   Definitions only.
`ifndef HSPP_REGS_VH
`define HSPP_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HSPP_ADDR_W        8
`define HSPP_OFF_CTRL      8'h00
`define HSPP_OFF_STRAP     8'h04
`define HSPP_OFF_STATUS    8'h08
`define HSPP_OFF_MASK      8'h0c

// ****************************************************************
// Control fields
// ****************************************************************
`define HSPP_CTRL_PWR      0
`define HSPP_CTRL_LED1     1
`define HSPP_CTRL_LED2     2
`define HSPP_CTRL_LEDSUP   3
`define HSPP_CTRL_W        4
`define HSPP_CTRL_RST      4'h0

// ****************************************************************
// Strap readback fields
// ****************************************************************
`define HSPP_STRAP_METHOD_LO 0
`define HSPP_STRAP_FIXED_LO  2
`define HSPP_STRAP_POL       4
`define HSPP_STRAP_VALID     5
`define HSPP_STRAP_OC        6

// ****************************************************************
// Status and mask fields
// ****************************************************************
`define HSPP_ST_OC_SET     0
`define HSPP_ST_OC_CLR     1
`define HSPP_ST_CAPT       2
`define HSPP_ST_W          3
`define HSPP_ST_RST        3'h0

// ****************************************************************
// Encodings
// ****************************************************************
`define HSPP_METHOD_RSVD   2'h0
`define HSPP_METHOD_SMBUS  2'h1
`define HSPP_METHOD_STRAP  2'h2
`define HSPP_METHOD_EEPROM 2'h3
`define HSPP_SMBUS_ADDR    7'h2c
`define HSPP_FIXED_NONE    2'h0
`define HSPP_FIXED_P1      2'h1
`define HSPP_FIXED_P2LOW   2'h2
`define HSPP_FIXED_BOTHLOW 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define HSPP_SYNC_FILL     2'h3

`endif

// File: logic/hspp_pin_sync.v
// Purpose: Three-stage synchroniser for one pin with a settled-level output.
// Assumes: The pin is asynchronous to i_clk.
// Notes:   The settled level moves only when stages two and three agree.
`timescale 1ns/1ps

module hspp_pin_sync
#(
  parameter RESET_LEVEL = 1'b0
)
(
  input  wire i_clk,      // Core clock.
  input  wire i_reset_n,  // Asynchronous reset, active low.
  input  wire i_pin,      // Raw pin level.
  output reg  o_level,    // Settled level.
  output wire o_stable    // Stages two and three agree.
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  assign o_stable = (s2_reg == s3_reg);

  // ****************************************************************
  // Synchroniser chain
  // ****************************************************************
  // The first stage feeds only the second; nothing else looks at it.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s1_reg  <= RESET_LEVEL;
      s2_reg  <= RESET_LEVEL;
      s3_reg  <= RESET_LEVEL;
      o_level <= RESET_LEVEL;
    end
    else
    begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        o_level <= s3_reg;
    end
  end

endmodule

// File: logic/hspp_led_drive.v
// Purpose: Drives one indicator LED pin once strap sampling is over.
// Assumes: All inputs come from logic on i_clk.
// Notes:   The pin stays released while its strap is still being read.
`timescale 1ns/1ps

module hspp_led_drive
(
  input  wire i_clk,         // Core clock.
  input  wire i_reset_n,     // Asynchronous reset, active low.
  input  wire i_run,         // Strap capture finished.
  input  wire i_on,          // LED requested lit.
  input  wire i_active_low,  // LED lights on a low level.
  output reg  o_pin,         // Pin output level.
  output reg  o_pin_oe       // Pin output enable.
);

  // ****************************************************************
  // Pin driver
  // ****************************************************************
  // Releasing the pin in reset keeps the strap resistor readable.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
    end
    else
    begin
      o_pin    <= i_on ^ i_active_low;
      o_pin_oe <= i_run;
    end
  end

endmodule

// File: logic/hspp_strap_port_power.v
// Purpose: Strap capture, port power enable, indicator LEDs and over-current
//          sensing for a two-port hub, with a small register port.
// Assumes: 250 MHz i_clk; straps are quiet around reset release.
// Notes:   Straps are taken from settled synchroniser levels just after
//          the release, since an asynchronous reset cannot load a pin.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "hspp_regs.vh"

// Notes on behaviour
// - Fixed strap 00 none fixed, 01 port 1 fixed, 10 or 11 both fixed.
// - LED polarity: 00 both high, 01 port 1 low, 10 port 2 low.
// - Fixed strap 11 makes both LEDs active low and both ports fixed.
// - In reset the power enable level follows the polarity strap, staying off.
// - Polarity strap is captured at reset release and held until next reset.
// - Captured polarity 1 gives active high power enable, 0 active low.
// - Over-current input is active low and idles high through a pull-up.
// - Shared serial clock pin is captured as configuration method bit 0.
// - Dedicated select pin is captured as configuration method bit 1.
// - Method 00 reserved, 01 SMBus slave, 10 strap defaults, 11 EEPROM.
// - Fixed strap pins count only when the strap default method is chosen.
// - With LED support set by EEPROM or SMBus, LEDs are active low.
module hspp_strap_port_power
(
  input  wire                    i_clk,                         // Core clock.
  input  wire                    i_reset_n,                     // Async reset, low.
  input  wire                    i_power_enable_polarity_strap, // Polarity pin.
  input  wire                    i_config_method_bit0,          // Shared clock pin in.
  input  wire                    i_config_method_bit1,          // Select pin.
  input  wire                    i_overcurrent_in_low,          // Over-current, low.
  input  wire                    i_port1_indicator_led,         // LED1 pin in.
  input  wire                    i_port2_indicator_led,         // LED2 pin in.
  input  wire                    i_serial_clock_low,            // Core pulls clock low.
  input  wire [`HSPP_ADDR_W-1:0] i_addr,                        // Register address.
  input  wire [31:0]             i_wr_data,                     // Write data.
  input  wire                    i_wr,                          // Write strobe.
  input  wire                    i_rd,                          // Read strobe.
  output reg  [31:0]             o_rd_data,                     // Read data.
  output reg                     o_irq,                         // Interrupt, high.
  output wire                    o_downstream_power_enable,     // Power switch.
  output reg                     o_serial_clock,                // Clock pin out.
  output reg                     o_serial_clock_oe,             // Clock pin enable.
  output wire                    o_port1_indicator_led,         // LED1 pin out.
  output wire                    o_port1_indicator_led_oe,      // LED1 pin enable.
  output wire                    o_port2_indicator_led,         // LED2 pin out.
  output wire                    o_port2_indicator_led_oe,      // LED2 pin enable.
  output reg  [1:0]              o_config_method,               // Captured method.
  output reg                     o_port1_fixed,                 // Port 1 fixed.
  output reg                     o_port2_fixed,                 // Port 2 fixed.
  output reg                     o_straps_valid                 // Capture done.
);

  // ****************************************************************
  // Capture sequencer states
  // ****************************************************************
  localparam ST_FILL = 2'h0;
  localparam ST_CAPT = 2'h1;
  localparam ST_RUN  = 2'h2;

  reg  [1:0]             state_reg;
  reg  [1:0]             fill_reg;
  reg                    pol_reg;
  reg  [1:0]             fixed_reg;
  reg                    led1_low_reg;
  reg                    led2_low_reg;
  reg                    pwr_on_reg;
  reg  [`HSPP_CTRL_W-1:0] ctrl_reg;
  reg  [`HSPP_CTRL_W-1:0] ctrl_next;
  reg  [`HSPP_ST_W-1:0]  status_reg;
  reg  [`HSPP_ST_W-1:0]  status_next;
  reg  [`HSPP_ST_W-1:0]  mask_reg;
  reg                    oc_prev_reg;
  reg  [31:0]            rd_next;
  reg  [`HSPP_ST_W-1:0]  events;
  wire                   pol_lvl;
  wire                   sel0_lvl;
  wire                   sel1_lvl;
  wire                   oc_lvl;
  wire                   led1_lvl;
  wire                   led2_lvl;
  wire                   pol_ok;
  wire                   sel0_ok;
  wire                   sel1_ok;
  wire                   led1_ok;
  wire                   led2_ok;
  wire                   all_ok;
  wire                   run;
  wire                   led_sup;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  hspp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_pol
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_power_enable_polarity_strap),
    .o_level   (pol_lvl),
    .o_stable  (pol_ok)
  );

  hspp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sel0
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_config_method_bit0),
    .o_level   (sel0_lvl),
    .o_stable  (sel0_ok)
  );

  hspp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sel1
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_config_method_bit1),
    .o_level   (sel1_lvl),
    .o_stable  (sel1_ok)
  );

  // Resets high so that an idle input never reports an over-current.
  hspp_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_oc
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_overcurrent_in_low),
    .o_level   (oc_lvl),
    .o_stable  ()
  );

  hspp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_led1
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_port1_indicator_led),
    .o_level   (led1_lvl),
    .o_stable  (led1_ok)
  );

  hspp_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_led2
  (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_pin     (i_port2_indicator_led),
    .o_level   (led2_lvl),
    .o_stable  (led2_ok)
  );

  assign all_ok  = pol_ok & sel0_ok & sel1_ok & led1_ok & led2_ok;
  assign run     = (state_reg == ST_RUN);
  assign led_sup = ctrl_reg[`HSPP_CTRL_LEDSUP];

  // ****************************************************************
  // Strap capture sequencer
  // ****************************************************************
  // The chain needs three edges to carry real pin levels, so capture
  // waits for the fill count and then for every strap to agree.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_reg       <= ST_FILL;
      fill_reg        <= 2'h0;
      pol_reg         <= 1'b0;
      fixed_reg       <= `HSPP_FIXED_NONE;
      o_config_method <= `HSPP_METHOD_RSVD;
      o_port1_fixed   <= 1'b0;
      o_port2_fixed   <= 1'b0;
      o_straps_valid  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_FILL:
        begin
          fill_reg <= fill_reg + 2'h1;
          if (fill_reg == `HSPP_SYNC_FILL)
            state_reg <= ST_CAPT;
        end
        ST_CAPT:
        begin
          if (all_ok)
          begin
            state_reg          <= ST_RUN;
            o_straps_valid     <= 1'b1;
            pol_reg            <= pol_lvl;
            o_config_method[0] <= sel0_lvl;
            o_config_method[1] <= sel1_lvl;
            if ({sel1_lvl, sel0_lvl} == `HSPP_METHOD_STRAP)
            begin
              fixed_reg     <= {led2_lvl, led1_lvl};
              o_port1_fixed <= led1_lvl | led2_lvl;
              o_port2_fixed <= led2_lvl;
            end
          end
        end
        ST_RUN:
          state_reg <= ST_RUN;
        default:
          state_reg <= ST_FILL;
      endcase
    end
  end

  // ****************************************************************
  // LED polarity
  // ****************************************************************
  // Strap defaults take their polarity from the fixed strap; the
  // downloaded methods follow the LED support setting instead.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      led1_low_reg <= 1'b0;
      led2_low_reg <= 1'b0;
    end
    else if (o_config_method == `HSPP_METHOD_STRAP)
    begin
      led1_low_reg <= (fixed_reg == `HSPP_FIXED_P1) |
                      (fixed_reg == `HSPP_FIXED_BOTHLOW);
      led2_low_reg <= fixed_reg[1];
    end
    else
    begin
      led1_low_reg <= led_sup;
      led2_low_reg <= led_sup;
    end
  end

  hspp_led_drive u_led1
  (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_run        (run),
    .i_on         (ctrl_reg[`HSPP_CTRL_LED1]),
    .i_active_low (led1_low_reg),
    .o_pin        (o_port1_indicator_led),
    .o_pin_oe     (o_port1_indicator_led_oe)
  );

  hspp_led_drive u_led2
  (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_run        (run),
    .i_on         (ctrl_reg[`HSPP_CTRL_LED2]),
    .i_active_low (led2_low_reg),
    .o_pin        (o_port2_indicator_led),
    .o_pin_oe     (o_port2_indicator_led_oe)
  );

  // ****************************************************************
  // Serial clock pin and port power
  // ****************************************************************
  // The clock pin is open drain: enabled only while pulling low.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_serial_clock    <= 1'b0;
      o_serial_clock_oe <= 1'b0;
      pwr_on_reg        <= 1'b0;
    end
    else
    begin
      o_serial_clock    <= 1'b0;
      o_serial_clock_oe <= run & i_serial_clock_low;
      pwr_on_reg        <= run & ctrl_reg[`HSPP_CTRL_PWR];
    end
  end

  // Until the polarity is captured the enable shows the inactive level
  // of the live strap through gates alone; a flop cannot load a pin
  // level under asynchronous reset, so this output is not registered.
  assign o_downstream_power_enable = o_straps_valid ?
                                     (pwr_on_reg ~^ pol_reg) :
                                     ~i_power_enable_polarity_strap;

  // ****************************************************************
  // Events and control register
  // ****************************************************************
  // An over-current also drops the power request; the hardware clear
  // wins over a software write in the same cycle.
  always @*
  begin
    events                    = {`HSPP_ST_W{1'b0}};
    events[`HSPP_ST_OC_SET]   = oc_prev_reg & ~oc_lvl;
    events[`HSPP_ST_OC_CLR]   = ~oc_prev_reg & oc_lvl;
    events[`HSPP_ST_CAPT]     = (state_reg == ST_CAPT) & all_ok;
    ctrl_next                 = ctrl_reg;
    if (i_wr && i_addr == `HSPP_OFF_CTRL)
      ctrl_next = i_wr_data[`HSPP_CTRL_W-1:0];
    if (events[`HSPP_ST_OC_SET])
      ctrl_next[`HSPP_CTRL_PWR] = 1'b0;
    status_next = status_reg;
    if (i_rd && i_addr == `HSPP_OFF_STATUS)
      status_next = {`HSPP_ST_W{1'b0}};
    status_next = status_next | events;
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always @*
  begin
    rd_next = 32'h0;
    case (i_addr)
      `HSPP_OFF_CTRL:
        rd_next[`HSPP_CTRL_W-1:0] = ctrl_reg;
      `HSPP_OFF_STRAP:
      begin
        rd_next[`HSPP_STRAP_METHOD_LO+1:`HSPP_STRAP_METHOD_LO] = o_config_method;
        rd_next[`HSPP_STRAP_FIXED_LO+1:`HSPP_STRAP_FIXED_LO]   = fixed_reg;
        rd_next[`HSPP_STRAP_POL]   = pol_reg;
        rd_next[`HSPP_STRAP_VALID] = o_straps_valid;
        rd_next[`HSPP_STRAP_OC]    = ~oc_lvl;
      end
      `HSPP_OFF_STATUS:
        rd_next[`HSPP_ST_W-1:0] = status_reg;
      `HSPP_OFF_MASK:
        rd_next[`HSPP_ST_W-1:0] = mask_reg;
      default:
        rd_next = 32'h0;
    endcase
  end

  // ****************************************************************
  // Register state and interrupt
  // ****************************************************************
  // Read data stands in each cycle after a read strobe and is zero otherwise.
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      ctrl_reg    <= `HSPP_CTRL_RST;
      status_reg  <= `HSPP_ST_RST;
      mask_reg    <= `HSPP_ST_RST;
      oc_prev_reg <= 1'b1;
      o_rd_data   <= 32'h0;
      o_irq       <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      status_reg  <= status_next;
      oc_prev_reg <= oc_lvl;
      if (i_wr && i_addr == `HSPP_OFF_MASK)
        mask_reg <= i_wr_data[`HSPP_ST_W-1:0];
      o_rd_data <= i_rd ? rd_next : 32'h0;
      o_irq     <= |(status_next & mask_reg);
    end
  end

endmodule

// File: testbench/hspp_board_model.sv
// Purpose: Board side of the hub: strap resistors, pull-ups and current monitor.
// Assumes: Strap levels are chosen by the bench.
// Notes:   A released pin shows its resistor level, never the last driven value.
`timescale 1ns/1ps

module hspp_board_model
(
  input  wire       i_method0, // Strap on the clock pin.
  input  wire [1:0] i_fixed,   // Straps on the LED pins.
  input  wire       i_fault,   // Monitor sees over-current.
  input  wire       i_scl_oe,  // Hub pulls the clock low.
  input  wire [1:0] i_led,     // Hub LED levels.
  input  wire [1:0] i_led_oe,  // Hub LED enables.
  output wire       o_scl,     // Clock pin level.
  output wire [1:0] o_led,     // LED pin levels.
  output wire       o_oc_n     // Monitor output, low on fault.
);
  // ********
  // Pin levels
  // ********
  // Open drain clock: only a low is driven, the resistor gives the rest.
  assign o_scl = i_scl_oe ? 1'b0 : i_method0;
  // Each LED pin is the hub's level while enabled, else its strap resistor.
  assign o_led = (i_led & i_led_oe) | (i_fixed & ~i_led_oe);
  // The monitor only pulls low; the pad pull-up gives the idle high.
  assign o_oc_n = ~i_fault;
endmodule

// File: testbench/hspp_strap_port_power_chk.sv
// Purpose: Assertions on strap capture, port power and shared pin ports.
// Assumes: Straps stay steady from reset until capture.
// Notes:   Bound to the top module, connections by name.
`timescale 1ns/1ps

module hspp_chk
(
  input wire       i_clk,                         // Clock.
  input wire       i_reset_n,                     // Reset, low.
  input wire       i_power_enable_polarity_strap, // Polarity.
  input wire       i_config_method_bit0,          // Method bit 0.
  input wire       i_config_method_bit1,          // Method bit 1.
  input wire       i_overcurrent_in_low,          // Over-current.
  input wire       i_port1_indicator_led,         // LED1 pin.
  input wire       i_port2_indicator_led,         // LED2 pin.
  input wire       i_wr,                          // Write.
  input wire       i_rd,                          // Read.
  input wire [31:0] o_rd_data,                    // Read data.
  input wire       o_downstream_power_enable,     // Power.
  input wire       o_serial_clock,                // Clock out.
  input wire       o_serial_clock_oe,             // Clock enable.
  input wire       o_port1_indicator_led_oe,      // LED1 enable.
  input wire       o_port2_indicator_led_oe,      // LED2 enable.
  input wire [1:0] o_config_method,               // Method.
  input wire       o_port1_fixed,                 // Port 1 fixed.
  input wire       o_port2_fixed,                 // Port 2 fixed.
  input wire       o_straps_valid                 // Capture done.
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Short aliases keep the properties readable.
  wire pwr = o_downstream_power_enable;
  wire pol = i_power_enable_polarity_strap;
  wire vld = o_straps_valid;
  sequence s_capt;
    $rose(vld);
  endsequence
  sequence s_fault;
    (vld && !i_overcurrent_in_low) [*3];
  endsequence
  // ********
  // Properties
  // ********
  a_pwr_precapt: assert property (!vld |-> pwr == !pol)
    else $error("Power enable active before capture.");
  a_pwr_first: assert property (s_capt |=> pwr == !pol)
    else $error("Power enable active with power off.");
  a_pwr_held: assert property (vld && $changed(pol) && !$past(i_wr) && !$past(i_wr, 2) |-> $stable(pwr))
    else $error("Power enable followed a live strap.");
  a_method_capt: assert property (s_capt |-> o_config_method == {i_config_method_bit1, i_config_method_bit0})
    else $error("Method differs from strap pins.");
  a_fixed_decode: assert property (s_capt |-> {o_port2_fixed, o_port1_fixed} == ((o_config_method == 2'h2) ?
    {i_port2_indicator_led, i_port1_indicator_led | i_port2_indicator_led} : 2'h0))
    else $error("Fixed ports decoded wrongly.");
  a_capt_held: assert property (vld |=> vld && $stable(o_config_method))
    else $error("Captured straps changed.");
  a_pins_free: assert property (!vld |-> !(o_serial_clock_oe || o_port1_indicator_led_oe || o_port2_indicator_led_oe))
    else $error("Shared pin driven before capture.");
  a_leds_driven: assert property (s_capt |=> o_port1_indicator_led_oe && o_port2_indicator_led_oe)
    else $error("LED pins not driven after capture.");
  a_scl_open: assert property (o_serial_clock == 1'b0)
    else $error("Clock pin driven high.");
  a_oc_power: assert property (s_fault |-> ##[0:4] pwr == !pol)
    else $error("Power left on during over-current.");
  a_rd_idle: assert property (!i_rd |=> o_rd_data == 32'h0)
    else $error("Read data outside a read.");
endmodule

bind hspp_strap_port_power hspp_chk i_chk
(
  .i_clk, .i_reset_n, .i_power_enable_polarity_strap, .i_config_method_bit0, .i_config_method_bit1,
  .i_overcurrent_in_low, .i_port1_indicator_led, .i_port2_indicator_led, .i_wr, .i_rd, .o_rd_data,
  .o_downstream_power_enable, .o_serial_clock, .o_serial_clock_oe, .o_port1_indicator_led_oe,
  .o_port2_indicator_led_oe, .o_config_method, .o_port1_fixed, .o_port2_fixed, .o_straps_valid
);

// File: testbench/hspp_strap_port_power_test.sv
// Purpose: Self-checking bench for straps, port power, LEDs and interrupt.
// Assumes: Method and fixed straps change only while reset is held; the polarity strap also flips after capture.
// Notes:   Reads push their expected word; a monitor compares the answers.
`timescale 1ns/1ps
`include "hspp_regs.vh"

module hspp_strap_port_power_test;
  // ********
  // Signals
  // ********
  reg                    clk = 1'b0;
  reg                    rst_n = 1'b0;
  reg                    pol = 1'b0;
  reg  [1:0]             meth = 2'h0;
  reg  [1:0]             fixd = 2'h0;
  reg                    fault = 1'b0;
  reg                    scl_low = 1'b0;
  reg  [`HSPP_ADDR_W-1:0] addr = 8'h00;
  reg  [31:0]            wdata = 32'h0;
  reg                    wr = 1'b0;
  reg                    rd = 1'b0;
  reg                    rd_d = 1'b0;
  reg  [31:0]            rnd;
  reg  [31:0]            exp_q[$];
  integer                seed = 32'hd1c1;
  integer                fail_count = 0;
  integer                samples_checked = 0;
  wire [31:0]            rd_data;
  wire                   irq, pwr, scl, scl_oe, oc_n, p1f, p2f, vld;
  wire [1:0]             led, led_oe, led_pin, cfg;

  hspp_board_model i_board
  (.i_method0(meth[0]), .i_fixed(fixd), .i_fault(fault), .i_scl_oe(scl_oe), .i_led(led),
   .i_led_oe(led_oe), .o_scl(scl), .o_led(led_pin), .o_oc_n(oc_n));
  hspp_strap_port_power i_dut
  (.i_clk(clk), .i_reset_n(rst_n), .i_power_enable_polarity_strap(pol), .i_config_method_bit0(scl),
   .i_config_method_bit1(meth[1]), .i_overcurrent_in_low(oc_n), .i_port1_indicator_led(led_pin[0]),
   .i_port2_indicator_led(led_pin[1]), .i_serial_clock_low(scl_low), .i_addr(addr), .i_wr_data(wdata),
   .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data), .o_irq(irq), .o_downstream_power_enable(pwr),
   .o_serial_clock(), .o_serial_clock_oe(scl_oe), .o_port1_indicator_led(led[0]),
   .o_port1_indicator_led_oe(led_oe[0]), .o_port2_indicator_led(led[1]),
   .o_port2_indicator_led_oe(led_oe[1]), .o_config_method(cfg), .o_port1_fixed(p1f),
   .o_port2_fixed(p2f), .o_straps_valid(vld));

  // A 4 ns clock.
  always #2 clk = ~clk;

  // ********
  // Tasks
  // ********
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One strobe cycle; a read also queues the word it should return.
  task access(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Waits for capture (0) or interrupt (1) at falling edges.
  task await(input integer sel);
    integer n;
    n = 0;
    while (n < 40 && (sel ? irq : vld) !== 1'b1)
    begin
      @(negedge clk);
      n = n + 1;
    end
    if (n == 40)
    begin
      fail_count = fail_count + 1;
      conclude;
    end
  endtask

  // Twelve cycles of reset with new straps; polarity flips in reset.
  task restart(input [1:0] m, input [1:0] f);
    @(posedge clk);
    rst_n <= 1'b0;
    meth <= m;
    fixd <= f;
    rnd = $random(seed);
    pol <= rnd[0];
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("power in reset", pwr, !pol);
    @(posedge clk);
    pol <= ~pol;
    @(negedge clk);
    check("power follows strap", pwr, !pol);
    @(posedge clk);
    rst_n <= 1'b1;
    await(0);
  endtask

  // Read answers stand the cycle after the strobe.
  always @(posedge clk)
    rd_d <= rd;
  always @(negedge clk)
    if (rd_d)
    begin
      if (exp_q.size() == 0)
        fail_count = fail_count + 1;
      else
        check("read data", rd_data, exp_q.pop_front());
    end

  // ********
  // Sequence
  // ********
  initial
  begin : main
    integer i;
    reg [1:0] f;
    reg [1:0] al;
    reg       c;
    reg       ls;
    // Every method and fixed strap, random polarity.
    for (i = 0; i < 16; i = i + 1)
    begin
      restart(i[3:2], i[1:0]);
      c = pol;
      f = (meth == 2'h2) ? fixd : 2'h0;
      check("fixed ports", {p2f, p1f}, {f[1], f[0] | f[1]});
      check("method", cfg, meth);
      access(1'b1, `HSPP_OFF_STRAP, 32'hffffffff);
      access(1'b0, `HSPP_OFF_STRAP, {25'h0, 2'b01, c, f, meth});
      access(1'b0, `HSPP_OFF_STATUS, 32'h4);
      access(1'b0, `HSPP_OFF_STATUS, 32'h0);
      access(1'b0, 8'h10, 32'h0);
      rnd = $random(seed);
      ls = rnd[0];
      al = (meth == 2'h2) ? fixd : {ls, ls};
      access(1'b1, `HSPP_OFF_CTRL, {28'h0, ls, 3'h7});
      access(1'b0, `HSPP_OFF_CTRL, {28'h0, ls, 3'h7});
      repeat (2) @(posedge clk);
      pol <= ~c;
      @(negedge clk);
      check("power on", pwr, c);
      check("leds lit", led, {~al});
      check("led enables", led_oe, 2'h3);
      @(posedge clk);
      pol <= c;
      access(1'b1, `HSPP_OFF_CTRL, {28'h0, ls, 3'h0});
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("power off", pwr, !c);
      check("leds dark", led, al);
    end
    // Over-current raises the interrupt, cuts power; release stays masked.
    access(1'b1, `HSPP_OFF_MASK, 32'h1);
    access(1'b1, `HSPP_OFF_CTRL, 32'h1);
    @(posedge clk);
    fault <= 1'b1;
    scl_low <= 1'b1;
    await(1);
    check("clock pulled", scl_oe, 1'b1);
    @(negedge clk);
    check("power cut", pwr, !c);
    access(1'b0, `HSPP_OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    fault <= 1'b0;
    scl_low <= 1'b0;
    @(negedge clk);
    check("irq cleared", irq, 1'b0);
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("irq masked", irq, 1'b0);
    access(1'b0, `HSPP_OFF_STATUS, 32'h2);
    repeat (3) @(posedge clk);
    conclude;
  end
endmodule
